// ==== rtl/osd_pixel_override_effects.sv ====
// Pixel-override effects of the character generator: shadow, border, boxes, row repeat
// Operation
// - Shadow uses the line above each fetched 12-bit line to build a mask.
// - Current bit X is compared with bit X+1 of the line above.
// - Bit 11 of a line is never shadowed.
// - Shadow-masked pixels take the heavy lowlight colour.
// - Border uses lines above and below and all eight neighbours.
// - Border-masked pixels take the heavy lowlight colour.
// - Border may be wrong in rows 0 and 17 and columns 0 and 11.
// - Rows of the 18-row matrix repeat to keep character height constant.
// - A character never shows fewer than its 18 matrix rows.
// - Two-colour codes 00h and 01h are window end and row end.
// - Irregular boxes may lose edges; no completion is attempted.
// - Box bit enables; bits 1 and 2 pick raised/depressed and normal/heavy colours, bit 0 blinks.
// - Boxes overwrite only top line and right column; neighbours draw the rest.
// - Feature field selects normal, blink, shadow, border or box variants.
`timescale 1ns/1ps
`include "osd_override_map.svh"
module osd_pixel_override_effects
   import osd_override_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdData,
   input  wire logic        fetchValid,
   input  wire fetch_s      fetch,
   output logic             fetchReady,
   input  wire logic        charStart,
   input  wire logic        lineStep,
   output logic      [4:0]  matrixRow,
   output logic             pixValid,
   output pixel_s           pix,
   output logic             windowEndPulse,
   output logic             rowEndPulse
);
   // Register file
   logic [1:0]  ctrl_ff;
   logic [1:0]  nxt_ctrl;
   logic [8:0]  hilite_ff;
   logic [8:0]  nxt_hilite;
   logic [8:0]  lolite_ff;
   logic [8:0]  nxt_lolite;
   logic [8:0]  heavyLo_ff;
   logic [8:0]  nxt_heavyLo;
   logic [10:0] nominal_ff;
   logic [10:0] nxt_nominal;
   logic [10:0] active_ff;
   logic [10:0] nxt_active;
   logic [15:0] rdData_ff;
   logic [15:0] nxt_rdData;

   // Pixel engine
   shift_state_e state_ff;
   shift_state_e nxt_state;
   fetch_s       hold_ff;
   fetch_s       nxt_hold;
   logic [11:0]  mask_ff;
   logic [11:0]  nxt_mask;
   logic [3:0]   idx_ff;
   logic [3:0]   nxt_idx;
   logic         ready_ff;
   logic         nxt_ready;
   logic         pixValid_ff;
   logic         nxt_pixValid;
   pixel_s       pix_ff;
   pixel_s       nxt_pix;
   logic         winEnd_ff;
   logic         nxt_winEnd;
   logic         rowEnd_ff;
   logic         nxt_rowEnd;
   logic [4:0]   rowOut_ff;

   logic [11:0]  fetchMask;
   logic [4:0]   repeatRow;
   logic         fetchTake;
   logic         isCtrlCode;

   shadow_border_mask u_mask (
      .lineAbove (fetch.lineAbove),
      .lineCur   (fetch.lineCur),
      .lineBelow (fetch.lineBelow),
      .borderMode(fetch.feature == `OSD_FEAT_BORDER),
      .mask      (fetchMask)
   );

   row_repeat_ctrl u_rows (
      .clk         (clk),
      .srst        (srst),
      .enable      (ctrl_ff[`OSD_CTRL_HEIGHT_EN]),
      .nominalLines(nominal_ff),
      .activeLines (active_ff),
      .charStart   (charStart),
      .lineStep    (lineStep),
      .matrixRow   (repeatRow)
   );

   // Register writes and reads
   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_hilite  = hilite_ff;
      nxt_lolite  = lolite_ff;
      nxt_heavyLo = heavyLo_ff;
      nxt_nominal = nominal_ff;
      nxt_active  = active_ff;
      nxt_rdData  = 16'h0000;
      if (regWr) begin
         unique case (regAddr)
            `OSD_REG_CTRL:          nxt_ctrl    = regWrData[1:0];
            `OSD_REG_HILITE:        nxt_hilite  = regWrData[8:0];
            `OSD_REG_LOLITE:        nxt_lolite  = regWrData[8:0];
            `OSD_REG_HEAVY_LOLITE:  nxt_heavyLo = regWrData[8:0];
            `OSD_REG_NOMINAL_LINES: nxt_nominal = regWrData[10:0];
            `OSD_REG_ACTIVE_LINES:  nxt_active  = regWrData[10:0];
            default: begin
            end
         endcase
      end
      if (regRd) begin
         unique case (regAddr)
            `OSD_REG_CTRL:          nxt_rdData = {14'h0000, ctrl_ff};
            `OSD_REG_HILITE:        nxt_rdData = {7'h00, hilite_ff};
            `OSD_REG_LOLITE:        nxt_rdData = {7'h00, lolite_ff};
            `OSD_REG_HEAVY_LOLITE:  nxt_rdData = {7'h00, heavyLo_ff};
            `OSD_REG_NOMINAL_LINES: nxt_rdData = {5'h00, nominal_ff};
            `OSD_REG_ACTIVE_LINES:  nxt_rdData = {5'h00, active_ff};
            `OSD_REG_STATUS:        nxt_rdData = {10'h000, (state_ff == ST_SHIFT), repeatRow};
            default:                nxt_rdData = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_ff    <= `OSD_CTRL_RST;
         hilite_ff  <= `OSD_COLOR_RST;
         lolite_ff  <= `OSD_COLOR_RST;
         heavyLo_ff <= `OSD_COLOR_RST;
         nominal_ff <= `OSD_LINES_RST;
         active_ff  <= `OSD_LINES_RST;
         rdData_ff  <= 16'h0000;
      end else begin
         ctrl_ff    <= nxt_ctrl;
         hilite_ff  <= nxt_hilite;
         lolite_ff  <= nxt_lolite;
         heavyLo_ff <= nxt_heavyLo;
         nominal_ff <= nxt_nominal;
         active_ff  <= nxt_active;
         rdData_ff  <= nxt_rdData;
      end
   end

   // Lowlight colour of a box: normal or heavy
   function automatic logic [8:0] lowColor(input logic [3:0] feat,
                                           input logic [8:0] lo,
                                           input logic [8:0] heavyLo);
      lowColor = feat[`OSD_FEAT_HEAVY_BIT] ? heavyLo : lo;
   endfunction : lowColor

   // Colour of one pixel after every override
   function automatic pixel_s pixelAt(input fetch_s   f,
                                      input logic [11:0] m,
                                      input logic [3:0]  x,
                                      input logic        blinkHide,
                                      input logic [8:0]  hi,
                                      input logic [8:0]  lo,
                                      input logic [8:0]  heavyLo);
      logic ownBox;
      logic rightBox;
      logic aboveBox;
      logic blinkOn;
      logic lit;
      ownBox   = f.feature[`OSD_FEAT_BOX_BIT];
      rightBox = f.rightFeature[`OSD_FEAT_BOX_BIT];
      aboveBox = f.aboveFeature[`OSD_FEAT_BOX_BIT];
      // Box codes carry blink in the low bit; 01xx is reserved and acts as normal
      blinkOn  = ownBox ? f.feature[`OSD_FEAT_BLINK_BIT]
                        : (f.feature == `OSD_FEAT_BLINK);
      lit      = f.lineCur[x] & ~(blinkOn & blinkHide);
      pixelAt.fg       = lit;
      pixelAt.override = 1'b1;
      pixelAt.color    = lit ? f.fgColor : f.bgColor;
      // Box edges only ever overwrite the top line and right column of a cell
      if (ownBox && f.firstLine) begin
         pixelAt.color = f.feature[`OSD_FEAT_DEPRESS_BIT] ?
                         lowColor(f.feature, lo, heavyLo) : hi;
      end else if (ownBox && (x == 4'h0)) begin
         pixelAt.color = f.feature[`OSD_FEAT_DEPRESS_BIT] ?
                         hi : lowColor(f.feature, lo, heavyLo);
      end else if (rightBox && (x == 4'h0)) begin
         // Left edge of the box to the right
         pixelAt.color = f.rightFeature[`OSD_FEAT_DEPRESS_BIT] ?
                         lowColor(f.rightFeature, lo, heavyLo) : hi;
      end else if (aboveBox && f.firstLine) begin
         // Bottom edge of the box above, no edge completion otherwise
         pixelAt.color = f.aboveFeature[`OSD_FEAT_DEPRESS_BIT] ?
                         hi : lowColor(f.aboveFeature, lo, heavyLo);
      end else if (m[x]) begin
         pixelAt.color = heavyLo;
      end else begin
         pixelAt.override = 1'b0;
      end
   endfunction : pixelAt

   assign fetchTake  = fetchValid & ready_ff;
   assign isCtrlCode = (fetch.code == `OSD_CODE_WINDOW_END) |
                       (fetch.code == `OSD_CODE_ROW_END);

   // Fetch acceptance and pixel serialiser, leftmost pixel (bit 11) first
   always_comb begin
      nxt_state    = state_ff;
      nxt_hold     = hold_ff;
      nxt_mask     = mask_ff;
      nxt_idx      = idx_ff;
      nxt_ready    = ready_ff;
      nxt_pixValid = 1'b0;
      nxt_pix      = pix_ff;
      nxt_winEnd   = 1'b0;
      nxt_rowEnd   = 1'b0;
      unique case (state_ff)
         ST_IDLE: begin
            nxt_ready = 1'b1;
            if (fetchTake) begin
               if (isCtrlCode) begin
                  // Control codes are never drawn
                  nxt_winEnd = (fetch.code == `OSD_CODE_WINDOW_END);
                  nxt_rowEnd = (fetch.code == `OSD_CODE_ROW_END);
               end else begin
                  nxt_hold  = fetch;
                  nxt_mask  = ((fetch.feature == `OSD_FEAT_SHADOW) |
                               (fetch.feature == `OSD_FEAT_BORDER)) ? fetchMask : 12'h000;
                  nxt_idx   = `OSD_LINE_MSB;
                  nxt_ready = 1'b0;
                  nxt_state = ST_SHIFT;
               end
            end
         end
         ST_SHIFT: begin
            nxt_pixValid = 1'b1;
            nxt_pix      = pixelAt(hold_ff, mask_ff, idx_ff, ctrl_ff[`OSD_CTRL_BLINK_HIDE],
                                   hilite_ff, lolite_ff, heavyLo_ff);
            if (idx_ff == 4'h0) begin
               nxt_ready = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_idx = idx_ff - 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff    <= ST_IDLE;
         hold_ff     <= '0;
         mask_ff     <= 12'h000;
         idx_ff      <= 4'h0;
         ready_ff    <= 1'b0;
         pixValid_ff <= 1'b0;
         pix_ff      <= '0;
         winEnd_ff   <= 1'b0;
         rowEnd_ff   <= 1'b0;
         rowOut_ff   <= 5'h00;
      end else begin
         state_ff    <= nxt_state;
         hold_ff     <= nxt_hold;
         mask_ff     <= nxt_mask;
         idx_ff      <= nxt_idx;
         ready_ff    <= nxt_ready;
         pixValid_ff <= nxt_pixValid;
         pix_ff      <= nxt_pix;
         winEnd_ff   <= nxt_winEnd;
         rowEnd_ff   <= nxt_rowEnd;
         rowOut_ff   <= repeatRow;
      end
   end

   assign regRdData      = rdData_ff;
   assign fetchReady     = ready_ff;
   assign matrixRow      = rowOut_ff;
   assign pixValid       = pixValid_ff;
   assign pix            = pix_ff;
   assign windowEndPulse = winEnd_ff;
   assign rowEndPulse    = rowEnd_ff;

endmodule : osd_pixel_override_effects

// ==== rtl/osd_override_map.svh ====
// Register map, field positions, reset values and codes of the pixel-override block
`ifndef OSD_OVERRIDE_MAP_SVH
`define OSD_OVERRIDE_MAP_SVH

`define OSD_REG_CTRL          4'h0
`define OSD_REG_HILITE        4'h1
`define OSD_REG_LOLITE        4'h2
`define OSD_REG_HEAVY_LOLITE  4'h3
`define OSD_REG_NOMINAL_LINES 4'h4
`define OSD_REG_ACTIVE_LINES  4'h5
`define OSD_REG_STATUS        4'h6

`define OSD_CTRL_HEIGHT_EN    0
`define OSD_CTRL_BLINK_HIDE   1
`define OSD_STATUS_BUSY       5

`define OSD_CTRL_RST          2'h1
`define OSD_COLOR_RST         9'h000
`define OSD_LINES_RST         11'h000

`define OSD_CODE_WINDOW_END   8'h00
`define OSD_CODE_ROW_END      8'h01

`define OSD_FEAT_NORMAL       4'h0
`define OSD_FEAT_BLINK        4'h1
`define OSD_FEAT_SHADOW       4'h2
`define OSD_FEAT_BORDER       4'h3
`define OSD_FEAT_BOX_BIT      3
`define OSD_FEAT_HEAVY_BIT    2
`define OSD_FEAT_DEPRESS_BIT  1
`define OSD_FEAT_BLINK_BIT    0

`define OSD_MATRIX_LAST_ROW   5'h11
`define OSD_LINE_MSB          4'hb

`endif

// ==== rtl/osd_override_pkg.sv ====
// Types shared by the pixel-override block
package osd_override_pkg;

   typedef struct packed {
      logic [7:0]  code;
      logic [3:0]  feature;
      logic [8:0]  fgColor;
      logic [8:0]  bgColor;
      logic [11:0] lineAbove;
      logic [11:0] lineCur;
      logic [11:0] lineBelow;
      logic        firstLine;
      logic [3:0]  rightFeature;
      logic [3:0]  aboveFeature;
   } fetch_s;

   typedef struct packed {
      logic       fg;
      logic       override;
      logic [8:0] color;
   } pixel_s;

   typedef enum logic [0:0] {
      ST_IDLE  = 1'b0,
      ST_SHIFT = 1'b1
   } shift_state_e;

endpackage : osd_override_pkg

// ==== rtl/shadow_border_mask.sv ====
// Shadow and border override mask for one 12-pixel character line
`timescale 1ns/1ps
module shadow_border_mask
   import osd_override_pkg::*;
(
   input  wire logic [11:0] lineAbove,
   input  wire logic [11:0] lineCur,
   input  wire logic [11:0] lineBelow,
   input  wire logic        borderMode,
   output logic      [11:0] mask
);
   logic [13:0] padA;
   logic [13:0] padC;
   logic [13:0] padB;

   always_comb begin
      // Outside the matrix counts as unlit
      padA = {1'b0, lineAbove, 1'b0};
      padC = {1'b0, lineCur, 1'b0};
      padB = {1'b0, lineBelow, 1'b0};
      mask = 12'h000;
      for (int x = 0; x < 12; x++) begin
         if (borderMode) begin
            mask[x] = ~lineCur[x] & (padA[x] | padA[x+1] | padA[x+2] | padC[x] | padC[x+2]
                                     | padB[x] | padB[x+1] | padB[x+2]);
         end else if (x < 11) begin
            mask[x] = ~lineCur[x] & lineAbove[x+1];
         end else begin
            mask[x] = 1'b0;
         end
      end
   end

endmodule : shadow_border_mask

// ==== rtl/row_repeat_ctrl.sv ====
// Matrix row selection that repeats rows to keep character height constant
`timescale 1ns/1ps
`include "osd_override_map.svh"
module row_repeat_ctrl
   import osd_override_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        enable,
   input  wire logic [10:0] nominalLines,
   input  wire logic [10:0] activeLines,
   input  wire logic        charStart,
   input  wire logic        lineStep,
   output logic      [4:0]  matrixRow
);
   logic [4:0]  row_ff;
   logic [4:0]  nxt_row;
   logic [11:0] acc_ff;
   logic [11:0] nxt_acc;
   logic [11:0] sum;
   logic        advance;

   always_comb begin
      nxt_row = row_ff;
      nxt_acc = acc_ff;
      sum     = acc_ff + {1'b0, nominalLines};
      advance = 1'b1;
      // Spread repeats evenly: advance when nominal/active share accumulates
      if (enable && (activeLines > nominalLines)) begin
         advance = (sum >= {1'b0, activeLines});
      end
      if (charStart) begin
         nxt_row = 5'h00;
         nxt_acc = 12'h000;
      end else if (lineStep) begin
         // At most one row per scan line, so never fewer than 18 lines
         if (advance && (row_ff != `OSD_MATRIX_LAST_ROW)) begin
            nxt_row = row_ff + 5'h01;
         end
         if (enable && (activeLines > nominalLines)) begin
            nxt_acc = advance ? (sum - {1'b0, activeLines}) : sum;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         row_ff <= 5'h00;
         acc_ff <= 12'h000;
      end else begin
         row_ff <= nxt_row;
         acc_ff <= nxt_acc;
      end
   end

   assign matrixRow = row_ff;

endmodule : row_repeat_ctrl

// ==== tb/osd_override_sva.sv ====
// Assertion checker for the pixel-override block
`timescale 1ns/1ps
module osd_override_sva
   import osd_override_pkg::*;
(
   input wire logic         clk,
   input wire logic         srst,
   input wire logic         fetchValid,
   input wire fetch_s       fetch,
   input wire logic         fetchReady,
   input wire logic         charStart,
   input wire logic         lineStep,
   input wire logic [4:0]   matrixRow,
   input wire logic         pixValid,
   input wire pixel_s       pix,
   input wire logic         windowEndPulse,
   input wire logic         rowEndPulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   logic takeDraw;
   logic takeCtl;
   assign takeDraw = fetchValid && fetchReady && (fetch.code > 8'h01);
   assign takeCtl  = fetchValid && fetchReady && (fetch.code <= 8'h01);

   property p_ready_drop; takeDraw |=> !fetchReady; endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("ready kept after take");
   property p_pix_len; takeDraw |-> ##2 pixValid ##11 pixValid ##1 !pixValid; endproperty
   a_pix_len: assert property (p_pix_len) else $error("pixel run not 12 cycles");
   property p_msb_clean;
      takeDraw && fetch.feature == 4'h2 && !fetch.firstLine |-> ##2 !pix.override;
   endproperty
   a_msb_clean: assert property (p_msb_clean) else $error("leftmost pixel shadowed");
   property p_normal_clean;
      takeDraw && fetch.feature == 4'h0 && !fetch.rightFeature[3] && !fetch.firstLine
         |-> ##2 (!pix.override)[*8] ##1 (!pix.override)[*4];
   endproperty
   a_normal_clean: assert property (p_normal_clean) else $error("plain line overridden");
   property p_win_end;
      takeCtl && fetch.code == 8'h00 |=> windowEndPulse && !rowEndPulse && !pixValid;
   endproperty
   a_win_end: assert property (p_win_end) else $error("window end not flagged");
   property p_row_end;
      takeCtl && fetch.code == 8'h01 |=> rowEndPulse && !windowEndPulse && !pixValid;
   endproperty
   a_row_end: assert property (p_row_end) else $error("row end not flagged");
   property p_ctl_ready; takeCtl |=> fetchReady; endproperty
   a_ctl_ready: assert property (p_ctl_ready) else $error("control code blocked fetch");
   property p_row_max; matrixRow <= 5'h11; endproperty
   a_row_max: assert property (p_row_max) else $error("row beyond matrix");
   property p_row_step;
      !$stable(matrixRow) |-> matrixRow == $past(matrixRow) + 5'h01 || matrixRow == 5'h00;
   endproperty
   a_row_step: assert property (p_row_step) else $error("row skipped");
   property p_row_restart; charStart && !lineStep ##1 !lineStep |=> matrixRow == 5'h00; endproperty
   a_row_restart: assert property (p_row_restart) else $error("row not restarted");
endmodule : osd_override_sva

// ==== tb/char_line_feeder.sv ====
// Model of the line fetch side: offers one character line until taken
`timescale 1ns/1ps
module char_line_feeder
   import osd_override_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   srst,
   input  wire logic   load,
   input  wire fetch_s loadData,
   input  wire logic   fetchReady,
   output logic        fetchValid,
   output fetch_s      fetch
);
   // Neighbour lines travel with each line; released data is inverted
   always_ff @(posedge clk) begin
      if (srst) begin
         fetchValid <= 1'b0;
         fetch      <= '0;
      end else if (fetchValid && fetchReady) begin
         fetchValid <= 1'b0;
         fetch      <= ~fetch;
      end else if (load) begin
         fetchValid <= 1'b1;
         fetch      <= loadData;
      end
   end
endmodule : char_line_feeder

// ==== tb/tb.sv ====
// Self-checking bench of the pixel-override block
`timescale 1ns/1ps
module tb
   import osd_override_pkg::*;
;
   logic        clk, srst, regWr, regRd, fetchValid, fetchReady, charStart, lineStep;
   logic [3:0]  regAddr;
   logic [15:0] regWrData, regRdData, rdv;
   logic [4:0]  matrixRow;
   logic        pixValid, windowEndPulse, rowEndPulse, load;
   fetch_s      fetch, loadData;
   pixel_s      pix;
   pixel_s      got [12];
   int          n_errors, compares;
   logic [8:0]  hi = 9'h0a1, lo = 9'h0b2, hv = 9'h0c3;

   osd_pixel_override_effects DUT (.clk(clk), .srst(srst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .fetchValid(fetchValid), .fetch(fetch), .fetchReady(fetchReady), .charStart(charStart),
      .lineStep(lineStep), .matrixRow(matrixRow), .pixValid(pixValid), .pix(pix),
      .windowEndPulse(windowEndPulse), .rowEndPulse(rowEndPulse));
   char_line_feeder feeder (.clk(clk), .srst(srst), .load(load), .loadData(loadData),
      .fetchReady(fetchReady), .fetchValid(fetchValid), .fetch(fetch));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge clk);
      regWr     <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      #1;
      rdv = regRdData;
   endtask : rd

   task automatic send(input fetch_s f, input int want);
      int n;
      n = 0;
      @(posedge clk);
      load     <= 1'b1;
      loadData <= f;
      @(posedge clk);
      load     <= 1'b0;
      for (int k = 0; k < 40 && n < want; k++) begin
         @(posedge clk);
         #1;
         if (pixValid === 1'b1) begin
            got[n] = pix;
            n++;
         end
      end
      if (n < want) begin
         n_errors++;
         final_report();
      end
   endtask : send

   task automatic pulse_steps(input int n);
      repeat (n) begin
         @(posedge clk);
         lineStep <= 1'b1;
         @(posedge clk);
         lineStep <= 1'b0;
      end
      repeat (3) @(posedge clk);
      #1;
   endtask : pulse_steps

   task automatic t_regs;
      rd(4'h0);
      check(rdv, 16'h0001, "ctrl reset");
      wr(4'h1, {7'h00, hi});
      wr(4'h2, {7'h00, lo});
      wr(4'h3, {7'h7f, hv});
      rd(4'h3);
      check(rdv, {7'h00, hv}, "heavy colour");
      @(posedge clk);
      #1;
      check(regRdData, 16'h0000, "read data one cycle");
      wr(4'hf, 16'hffff);
      rd(4'h1);
      check(rdv, {7'h00, hi}, "unmapped write ignored");
      rd(4'hf);
      check(rdv, 16'h0000, "unmapped read");
   endtask : t_regs

   task automatic t_effect(input logic [3:0] feat);
      fetch_s f;
      logic [13:0] a, c, b;
      logic m;
      f = '0;
      f.code = 8'h41;
      f.feature = feat;
      f.fgColor = 9'h111;
      f.bgColor = 9'h022;
      f.lineAbove = 12'h5a9;
      f.lineCur = 12'h3c6;
      f.lineBelow = 12'h0f0;
      a = {1'b0, f.lineAbove, 1'b0};
      c = {1'b0, f.lineCur, 1'b0};
      b = {1'b0, f.lineBelow, 1'b0};
      send(f, 12);
      for (int x = 0; x < 12; x++) begin
         if (feat == 4'h3) begin
            m = !c[x+1] && ((|a[x+2 -: 3]) || c[x+2] || c[x] || (|b[x+2 -: 3]));
         end else begin
            m = (feat == 4'h2) && !c[x+1] && a[x+2];
         end
         if (feat != 4'h3 || (x > 0 && x < 11)) begin
            check({5'h00, got[11-x]},
               {5'h00, c[x+1], m, m ? hv : (c[x+1] ? f.fgColor : f.bgColor)},
               "effect pixel");
         end
      end
   endtask : t_effect

   task automatic t_box;
      fetch_s f;
      logic [3:0] feats [4] = '{4'h8, 4'ha, 4'hc, 4'he};
      logic [8:0] right [4] = '{lo, hi, hv, hi};
      f = '0;
      f.code = 8'h42;
      f.lineCur = 12'h000;
      for (int i = 0; i < 4; i++) begin
         f.feature = feats[i];
         send(f, 12);
         check({7'h00, got[11].color}, {7'h00, right[i]}, "box right column");
         check({15'h0000, got[5].override}, 16'h0000, "box inner pixel");
      end
      f.feature = 4'h8;
      f.firstLine = 1'b1;
      send(f, 12);
      check({7'h00, got[0].color}, {7'h00, hi}, "box top line");
      // One blank skip line that is left of one box and under another box
      f.feature = 4'h0;
      f.aboveFeature = 4'hc;
      f.rightFeature = 4'ha;
      send(f, 12);
      check({7'h00, got[11].color}, {7'h00, lo}, "left edge of right box");
      check({7'h00, got[3].color}, {7'h00, hv}, "bottom edge on skip line");
   endtask : t_box

   task automatic t_blink;
      fetch_s f;
      logic [3:0] feats [3] = '{4'h1, 4'h9, 4'h8};
      logic [15:0] exp [3] = '{16'h0022, 16'h0022, 16'h0511};
      f = '0;
      f.code = 8'h43;
      f.fgColor = 9'h111;
      f.bgColor = 9'h022;
      f.lineCur = 12'hfff;
      wr(4'h0, 16'h0003);
      for (int i = 0; i < 3; i++) begin
         f.feature = feats[i];
         send(f, 12);
         check({5'h00, got[6]}, exp[i], "blink hide");
      end
      wr(4'h0, 16'h0001);
   endtask : t_blink

   task automatic t_codes;
      fetch_s f;
      int k;
      f = '0;
      // One window only, so window spacing and overlap never arise
      for (int i = 0; i < 2; i++) begin
         f.code = i[7:0];
         send(f, 0);
         for (k = 0; k < 10 && !(windowEndPulse === 1'b1 || rowEndPulse === 1'b1); k++) begin
            @(posedge clk);
            #1;
         end
         if (k == 10) begin
            n_errors++;
            final_report();
         end
         check({14'h0000, windowEndPulse, rowEndPulse}, (i == 0) ? 16'h0002 : 16'h0001,
            "control code");
         check({15'h0000, pixValid}, 16'h0000, "control code drawn");
      end
   endtask : t_codes

   task automatic t_height(input logic [10:0] nom, input logic [10:0] act);
      wr(4'h4, {5'h00, nom});
      wr(4'h5, {5'h00, act});
      @(posedge clk);
      charStart <= 1'b1;
      @(posedge clk);
      charStart <= 1'b0;
      pulse_steps(5);
      if (act <= nom) begin
         check({11'h000, matrixRow}, 16'h0005, "row per line");
      end else begin
         check({15'h0000, matrixRow < 5'h05}, 16'h0001, "row repeated");
      end
      pulse_steps(26);
      check({11'h000, matrixRow}, 16'h0011, "row saturates");
      rd(4'h6);
      check(rdv, 16'h0011, "row status");
   endtask : t_height

   initial begin
      srst = 1'b1;
      {regWr, regRd, load, charStart, lineStep} = '0;
      regAddr = '0;
      regWrData = '0;
      loadData = '0;
      n_errors = 0;
      compares = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs();
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         t_effect(i[3:0]);
      end
      $display("effects done");
      t_box();
      $display("boxes done");
      t_blink();
      $display("blink done");
      t_codes();
      $display("control codes done");
      t_height(11'h003, 11'h002);
      t_height(11'h002, 11'h003);
      $display("height done");
      final_report();
   end
endmodule : tb

bind osd_pixel_override_effects osd_override_sva chk (.clk(clk), .srst(srst),
   .fetchValid(fetchValid), .fetch(fetch), .fetchReady(fetchReady), .charStart(charStart),
   .lineStep(lineStep), .matrixRow(matrixRow), .pixValid(pixValid), .pix(pix),
   .windowEndPulse(windowEndPulse), .rowEndPulse(rowEndPulse));
